// File: src/adr_regs.sv
/*
 Register bank of a four-channel amplifier: three instruction registers
 and five read-clear status registers behind a byte-wide register port.
 Assumes a serial control engine supplies byte writes and read strobes,
 and the amplifier core supplies fault and state levels.
*/
`timescale 1ns/1ns
module adr_regs
	import adr_pkg::*;
(
	// Clocking
	input  wire logic                clock,
	input  wire logic                sys_rst,
	input  wire logic                clk_en,
	// Register port from serial engine
	input  wire logic                xfer_start,
	input  wire logic [4:0]          sub_addr,
	input  wire logic                auto_inc,
	input  wire logic                wr_stb,
	input  wire logic [7:0]          wr_data,
	input  wire logic                rd_stb,
	output logic      [7:0]          rd_data,
	// Amplifier core status
	input  wire adr_chan_flt_t [3:0] chan_flt,
	input  wire logic                turnon_done,
	input  wire logic [3:0]          tw_level,
	input  wire logic                mute_24,
	input  wire logic                mute_13,
	input  wire logic [3:0]          tweeter,
	input  wire logic                signal_high,
	input  wire logic                clip_det,
	input  wire logic                diag_enable,
	// Outputs to amplifier core
	output adr_ctrl_t                ctrl,
	output logic [3:0]               perm_restart,
	output logic                     diag_pin
);

	logic [7:0] routing_r;
	logic [7:0] protect_r;
	logic [7:0] acslot_r;
	logic [7:0] stat_r [5];
	logic [7:0] stat_live [5];
	logic [4:0] ptr_r;
	logic       out_tri_r;
	logic       cur_stat;
	logic [2:0] cur_idx;
	logic       any_short;
	logic       any_offset;

	// Register pointer with auto increment
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_r <= 5'h00;
		end else if (clk_en) begin
			if (xfer_start) begin
				ptr_r <= sub_addr;
			end else if ((wr_stb || rd_stb) && auto_inc
				&& ptr_r != ADR_LAST) begin
				ptr_r <= ptr_r + 5'h01;
			end
		end
	end

	// Instruction registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			routing_r <= RST_DIAG_PIN_ROUTING;
			protect_r <= RST_PROTECTION_CONFIG;
			acslot_r  <= RST_AC_DIAG_SLOT;
		end else if (clk_en && wr_stb) begin
			case (ptr_r)
				ADR_DIAG_PIN_ROUTING: begin
					routing_r <= wr_data & MSK_DIAG_PIN_ROUTING;
				end
				ADR_PROTECTION_CONFIG: begin
					protect_r <= wr_data & MSK_PROTECTION_CONFIG;
				end
				ADR_AC_DIAG_SLOT: begin
					acslot_r <= wr_data & MSK_AC_DIAG_SLOT;
				end
				default: begin
				end
			endcase
		end
	end

	// Left-tristate-since-reset flag
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			out_tri_r <= 1'b0;
		end else if (clk_en && protect_r[PC_TRI_CH3:PC_TRI_CH2] != 4'h0) begin
			out_tri_r <= out_tri_r;
		end else if (clk_en) begin
			out_tri_r <= 1'b1;
		end
	end

	// Live status composition
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			stat_live[i][5] = chan_flt[i].offset;
			stat_live[i][4] = chan_flt[i].perm_done;
			stat_live[i][3] = chan_flt[i].short_load;
			stat_live[i][2] = chan_flt[i].open_load & ~turnon_done;
			stat_live[i][1] = chan_flt[i].short_vcc;
			stat_live[i][0] = chan_flt[i].short_gnd;
		end
		stat_live[0][7:6] = {out_tri_r, turnon_done};
		stat_live[1][7:6] = tw_level[1:0] == 2'b00 ? 2'b00
			: {tw_level[0], tw_level[1]};
		stat_live[2][7:6] = {tw_level[2], tw_level[3]};
		stat_live[3][7:6] = {mute_24, mute_13};
		stat_live[4] = {tweeter[0], tweeter[1], tweeter[2], tweeter[3],
			signal_high, 3'b000};
	end

	assign cur_stat = ptr_r >= ADR_CH1_STATUS && ptr_r <= ADR_TWEETER_STATUS;
	assign cur_idx  = 3'(ptr_r - ADR_CH1_STATUS);

	// Status latches: events accumulate, read clears, set wins
	for (genvar g = 0; g < 5; g++) begin : g_stat
		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				stat_r[g] <= RST_STATUS;
			end else if (clk_en) begin
				if (rd_stb && cur_stat && cur_idx == 3'(g)) begin
					stat_r[g] <= stat_live[g];
				end else begin
					stat_r[g] <= stat_r[g] | stat_live[g];
				end
			end
		end
	end

	// Permanent diagnostic restart after each channel read
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			perm_restart <= 4'h0;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				perm_restart[i] <= rd_stb && cur_stat && cur_idx == 3'(i)
					&& diag_enable;
			end
		end
	end

	// Read data mux
	always_comb begin
		case (ptr_r)
			ADR_DIAG_PIN_ROUTING:  rd_data = routing_r;
			ADR_PROTECTION_CONFIG: rd_data = protect_r;
			ADR_AC_DIAG_SLOT:      rd_data = acslot_r;
			ADR_CH1_STATUS:        rd_data = stat_r[0];
			ADR_CH2_STATUS:        rd_data = stat_r[1];
			ADR_CH3_STATUS:        rd_data = stat_r[2];
			ADR_CH4_STATUS:        rd_data = stat_r[3];
			ADR_TWEETER_STATUS:    rd_data = stat_r[4];
			default:               rd_data = ADR_DIAG_ZERO;
		endcase
	end

	// Control decode
	always_comb begin
		ctrl.noise_gate_en = ~protect_r[PC_NGATE_OFF];
		ctrl.uv_mute_en    = ~protect_r[PC_UVMUTE_OFF];
		ctrl.tristate      = {protect_r[PC_TRI_CH4], protect_r[PC_TRI_CH3],
			protect_r[PC_TRI_CH2], protect_r[PC_TRI_CH1]};
		ctrl.hpf_en        = protect_r[PC_HPF_ON];
		ctrl.ac_diag_en    = acslot_r[AF_AC_ON];
		ctrl.ac_thr_low    = acslot_r[AF_AC_LOW];
		ctrl.slot_fmt      = adr_slot_t'(acslot_r[AF_SLOT_HI:AF_SLOT_LO]);
		ctrl.clip_level    = adr_clip_t'(routing_r[RT_CLIP_HI:RT_CLIP_LO]);
	end

	always_comb begin
		any_short  = 1'b0;
		any_offset = 1'b0;
		for (int i = 0; i < 4; i++) begin
			any_short  = any_short | chan_flt[i].short_load
				| chan_flt[i].short_vcc | chan_flt[i].short_gnd;
			any_offset = any_offset | chan_flt[i].offset;
		end
	end

	adr_diag_pin u_diag (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.clk_en     (clk_en),
		.routing    (routing_r),
		.any_short  (any_short),
		.any_offset (any_offset),
		.tw_level   (tw_level),
		.clip_det   (clip_det && ctrl.clip_level != ADR_CLIP_OFF),
		.diag_pin   (diag_pin)
	);

endmodule // adr_regs

// File: src/adr_pkg.sv
/*
 Package for the amplifier diagnostic/control register bank: register
 offsets, field positions, reset values and carrier structs.
 Assumes a 5-bit register subaddress delivered by a byte-level serial
 control engine outside this block.
*/
package adr_pkg;

	// Register subaddresses
	localparam logic [4:0] ADR_DIAG_PIN_ROUTING  = 5'h02;
	localparam logic [4:0] ADR_PROTECTION_CONFIG = 5'h03;
	localparam logic [4:0] ADR_AC_DIAG_SLOT      = 5'h04;
	localparam logic [4:0] ADR_CH1_STATUS        = 5'h10;
	localparam logic [4:0] ADR_CH2_STATUS        = 5'h11;
	localparam logic [4:0] ADR_CH3_STATUS        = 5'h12;
	localparam logic [4:0] ADR_CH4_STATUS        = 5'h13;
	localparam logic [4:0] ADR_TWEETER_STATUS    = 5'h14;
	localparam logic [4:0] ADR_LAST              = 5'h14;

	// Reset values
	localparam logic [7:0] RST_DIAG_PIN_ROUTING  = 8'h00;
	localparam logic [7:0] RST_PROTECTION_CONFIG = 8'h00;
	localparam logic [7:0] RST_AC_DIAG_SLOT      = 8'h00;
	localparam logic [7:0] RST_STATUS            = 8'h00;

	// Writable bit masks (reserved bits forced to zero)
	localparam logic [7:0] MSK_DIAG_PIN_ROUTING  = 8'hFE;
	localparam logic [7:0] MSK_PROTECTION_CONFIG = 8'hBF;
	localparam logic [7:0] MSK_AC_DIAG_SLOT      = 8'hF0;

	// Routing register fields
	localparam int RT_SHORT_EN   = 7;
	localparam int RT_OFFS_DIS_N = 6;
	localparam int RT_TW_HI      = 5;
	localparam int RT_TW_LO      = 3;
	localparam int RT_CLIP_HI    = 2;
	localparam int RT_CLIP_LO    = 1;

	// Protection register fields
	localparam int PC_NGATE_OFF  = 7;
	localparam int PC_UVMUTE_OFF = 5;
	localparam int PC_TRI_CH3    = 4;
	localparam int PC_TRI_CH1    = 3;
	localparam int PC_TRI_CH4    = 2;
	localparam int PC_TRI_CH2    = 1;
	localparam int PC_HPF_ON     = 0;

	// AC diag / slot format fields
	localparam int AF_AC_ON      = 7;
	localparam int AF_AC_LOW     = 6;
	localparam int AF_SLOT_HI    = 5;
	localparam int AF_SLOT_LO    = 4;

	// Status fields
	localparam int ST_OFFSET     = 5;
	localparam int ST_PERM_DONE  = 4;

	localparam logic [7:0] ADR_DIAG_ZERO = 8'h00;

	typedef enum logic [1:0] {
		ADR_CLIP_1PCT  = 2'b00,
		ADR_CLIP_5PCT  = 2'b01,
		ADR_CLIP_10PCT = 2'b10,
		ADR_CLIP_OFF   = 2'b11
	} adr_clip_t;

	typedef enum logic [1:0] {
		ADR_SLOT_2CH     = 2'b00,
		ADR_SLOT_4CH     = 2'b01,
		ADR_SLOT_8CH_FST = 2'b10,
		ADR_SLOT_8CH_LST = 2'b11
	} adr_slot_t;

	// Per-channel fault sources
	typedef struct packed {
		logic offset;
		logic perm_done;
		logic short_load;
		logic open_load;
		logic short_vcc;
		logic short_gnd;
	} adr_chan_flt_t;

	// Control outputs to the amplifier core
	typedef struct packed {
		logic       noise_gate_en;
		logic       uv_mute_en;
		logic [3:0] tristate;
		logic       hpf_en;
		logic       ac_diag_en;
		logic       ac_thr_low;
		adr_slot_t  slot_fmt;
		adr_clip_t  clip_level;
	} adr_ctrl_t;

endpackage

// File: src/adr_diag_pin.sv
/*
 Diagnostic pin combiner: merges short, offset, thermal and clip
 indications according to the routing register.
 Assumes fault inputs are synchronous levels from the amplifier core.
*/
`timescale 1ns/1ns
module adr_diag_pin
	import adr_pkg::*;
(
	// Clocking
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// Routing
	input  wire logic [7:0] routing,
	// Fault sources
	input  wire logic       any_short,
	input  wire logic       any_offset,
	input  wire logic [3:0] tw_level,
	input  wire logic       clip_det,
	// Pin
	output logic            diag_pin
);

	logic tw_sel;
	logic diag_nxt;

	always_comb begin
		tw_sel = 1'b0;
		if (!routing[RT_TW_HI]) begin
			tw_sel = tw_level[routing[RT_TW_HI-1:RT_TW_LO]];
		end
		diag_nxt = (routing[RT_SHORT_EN] & any_short)
			| (~routing[RT_OFFS_DIS_N] & any_offset)
			| tw_sel
			| clip_det;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			diag_pin <= 1'b0;
		end else if (clk_en) begin
			diag_pin <= diag_nxt;
		end
	end

endmodule // adr_diag_pin

// File: test/adr_regs_properties.sv
/* Checker bound to adr_regs.
 Assumes clk_en stays high. */
`timescale 1ns/1ns
module adr_regs_properties
	import adr_pkg::*;
(
	// Clock, reset, register port
	input logic       clock,
	input logic       sys_rst,
	input logic       xfer_start,
	input logic [4:0] sub_addr,
	input logic       auto_inc,
	input logic       wr_stb,
	input logic [7:0] wr_data,
	input logic       rd_stb,
	input logic [7:0] rd_data,
	// Core side
	input logic       diag_enable,
	input logic [3:0] tweeter,
	input logic       signal_high,
	input adr_ctrl_t  ctrl,
	input logic [3:0] perm_restart
);
	logic [4:0] ptr_r;
	logic [7:0] wd_r;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			ptr_r <= 5'h00;
		else if (xfer_start)
			ptr_r <= sub_addr;
		else if ((wr_stb || rd_stb) && auto_inc && ptr_r != 5'h14)
			ptr_r <= ptr_r + 5'h01;
	always_ff @(posedge clock)
		if (wr_stb)
			wd_r <= wr_data;
	a_reset_ctrl: assert property (
		$fell(sys_rst) |-> ctrl == 13'h1800) else $error("bad reset ctrl");
	a_prot_bits: assert property (
		wr_stb && ptr_r == 5'h03 |=> ctrl.noise_gate_en == !wd_r[7]
		&& ctrl.uv_mute_en == !wd_r[5] && ctrl.hpf_en == wd_r[0])
		else $error("bad protection ctrl");
	a_tristate_map: assert property (
		wr_stb && ptr_r == 5'h03 |=>
		ctrl.tristate == {wd_r[2], wd_r[4], wd_r[1], wd_r[3]})
		else $error("bad tristate map");
	a_ac_slot: assert property (
		wr_stb && ptr_r == 5'h04 |=> ctrl.ac_diag_en == wd_r[7]
		&& ctrl.ac_thr_low == wd_r[6] && ctrl.slot_fmt == wd_r[5:4])
		else $error("bad ac or slot ctrl");
	a_clip_level: assert property (
		wr_stb && ptr_r == 5'h02 |=> ctrl.clip_level == wd_r[2:1])
		else $error("bad clip level");
	a_reserved_zero: assert property (
		!(ptr_r == 5'h02 && rd_data[0] || ptr_r == 5'h03 && rd_data[6]
		|| ptr_r == 5'h04 && rd_data[3:0] != 4'h0))
		else $error("reserved bit reads one");
	a_perm_restart: assert property (
		rd_stb && diag_enable && ptr_r >= 5'h10 && ptr_r <= 5'h13
		|-> ##[1:2] perm_restart != 4'h0) else $error("no restart");
	a_read_clear: assert property (
		rd_stb && ptr_r == 5'h14 && tweeter == 4'h0 && !signal_high
		##1 ptr_r == 5'h14 && tweeter == 4'h0 && !signal_high
		|-> rd_data == 8'h00) else $error("status not cleared");
endmodule // adr_regs_properties
bind adr_regs adr_regs_properties u_props (.clock, .sys_rst, .xfer_start,
	.sub_addr, .auto_inc, .wr_stb, .wr_data, .rd_stb, .rd_data,
	.diag_enable, .tweeter, .signal_high, .ctrl, .perm_restart);

// File: test/adr_host.sv
/* Host model of the register port.
 Assumes each call starts just after a rising clock edge. */
`timescale 1ns/1ns
module adr_host (
	// Clock
	input logic        clock,
	// Register port
	output logic       xfer_start,
	output logic [4:0] sub_addr,
	output logic       auto_inc,
	output logic       wr_stb,
	output logic [7:0] wr_data,
	output logic       rd_stb,
	input logic [7:0]  rd_data
);
	initial begin
		{xfer_start, auto_inc, wr_stb, rd_stb} = 4'h0;
		sub_addr = 5'h00;
		wr_data = 8'h00;
	end
	task automatic st(input logic [4:0] a, input logic inc);
		xfer_start <= 1'b1;
		sub_addr <= a;
		auto_inc <= inc;
		@(posedge clock);
		xfer_start <= 1'b0;
		sub_addr <= ~a;
	endtask
	// Caller keeps routing bit 0 low
	task automatic wb(input logic [7:0] v);
		wr_stb <= 1'b1;
		wr_data <= v;
		@(posedge clock);
	endtask
	task automatic rb(output logic [7:0] v);
		rd_stb <= 1'b1;
		@(posedge clock);
		v = rd_data;
	endtask
	task automatic idle;
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		wr_data <= ~wr_data;
		@(posedge clock);
	endtask
endmodule // adr_host

// File: test/adr_regs_tb.sv
/* Bench for adr_regs.
 Assumes adr_host and the bound checker. */
`timescale 1ns/1ns
module adr_regs_tb
	import adr_pkg::*;
;
	localparam logic [7:0] EX [6] = '{8'h61, 8'h52, 8'h88, 8'hbb,
		8'hc8, 8'h00};
	localparam logic [31:0] PIN [8] = '{32'he608_0001, 32'h6608_0000,
		32'ha620_0001, 32'he620_0000, 32'h4e00_2001, 32'h6e00_f000,
		32'h4000_0101, 32'h4600_0100};
	logic clock, sys_rst, clk_en, xfer_start, auto_inc, wr_stb, rd_stb;
	logic turnon_done, mute_24, mute_13, signal_high, clip_det;
	logic diag_enable, diag_pin;
	logic [4:0] sub_addr;
	logic [3:0] tw_level, tweeter, perm_restart;
	logic [7:0] wr_data, rd_data, d, r2, r3, r4;
	adr_chan_flt_t [3:0] chan_flt;
	adr_ctrl_t ctrl;
	int error_cnt, n_tests, cyc;
	adr_regs dut (.clock, .sys_rst, .clk_en, .xfer_start, .sub_addr,
		.auto_inc, .wr_stb, .wr_data, .rd_stb, .rd_data, .chan_flt,
		.turnon_done, .tw_level, .mute_24, .mute_13, .tweeter,
		.signal_high, .clip_det, .diag_enable, .ctrl, .perm_restart,
		.diag_pin);
	adr_host host (.clock, .xfer_start, .sub_addr, .auto_inc, .wr_stb,
		.wr_data, .rd_stb, .rd_data);
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			close_out;
		end
	end
	initial begin
		{sys_rst, clk_en, diag_enable} = 3'h7;
		{turnon_done, mute_24, mute_13, signal_high, clip_det} = 5'h00;
		{tw_level, tweeter, chan_flt} = 32'h0000_0000;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		host.idle;
		chk(16'(ctrl), 16'h1800);
		host.st(5'h02, 1'b1);
		for (int k = 0; k < 3; k++) begin
			host.rb(d);
			chk(16'(d), 16'h0000);
		end
		for (int i = 0; i < 4; i++) begin
			r2 = {i[0], i[1], i[2:0], i[1:0], 1'b0};
			r3 = {i[1], 1'b1, i[0], ~i[1:0], i[1:0], i[0]};
			r4 = {i[0], i[1], i[1:0], 4'hf};
			host.idle;
			host.st(5'h02, 1'b1);
			host.wb(r2);
			host.wb(r3);
			host.wb(r4);
			host.idle;
			chk(16'(ctrl), 16'({~r3[7], ~r3[5], r3[2], r3[4], r3[1], r3[3],
				r3[0], r4[7:4], r2[2:1]}));
			host.st(5'h02, 1'b1);
			host.rb(d);
			chk(16'(d), 16'(r2));
			host.rb(d);
			chk(16'(d), 16'(r3 & 8'hbf));
			host.rb(d);
			chk(16'(d), 16'(r4 & 8'hf0));
		end
		$display("control test done");
		chan_flt <= {6'h3f, 6'h0c, 6'h12, 6'h21};
		{turnon_done, mute_24, signal_high} <= 3'h7;
		tw_level <= 4'h6;
		tweeter <= 4'h3;
		repeat (3) @(posedge clock);
		{turnon_done, mute_24, signal_high} <= 3'h0;
		{tw_level, tweeter, chan_flt} <= 32'h0000_0000;
		repeat (3) @(posedge clock);
		for (int p = 0; p < 2; p++) begin
			host.idle;
			host.st(5'h10, 1'b1);
			for (int k = 0; k < 6; k++) begin
				host.rb(d);
				chk(16'(d & (k == 0 ? 8'h7f : 8'hff)),
					16'(p == 0 ? EX[k] : 8'h00));
			end
		end
		$display("status test done");
		for (int k = 0; k < 8; k++) begin
			host.idle;
			host.st(5'h02, 1'b0);
			host.wb(PIN[k][31:24]);
			host.idle;
			chan_flt[0] <= PIN[k][21:16];
			tw_level <= PIN[k][15:12];
			clip_det <= PIN[k][8];
			repeat (4) @(posedge clock);
			chk(16'(diag_pin), 16'(PIN[k][7:0]));
		end
		$display("diag pin test done");
		close_out;
	end
endmodule // adr_regs_tb
